/* logic/pwm_stb_defines.vh */
/*
 * Constants for the secondary time base and chop clock block:
 * register word indices, field positions, reset values and codes.
 * Assumes inclusion by bare name from each design file.
 */
`ifndef PWM_STB_DEFINES_VH
`define PWM_STB_DEFINES_VH

// Register word indices on the Wishbone bus (byte address bits 7:2)
`define OFS_SEC_PRESCALE      6'h00
`define OFS_SEC_PERIOD        6'h01
`define OFS_SEC_COMPARE       6'h02
`define OFS_CHOP_CONTROL      6'h03
`define OFS_PRI_PRESCALE      6'h04
`define OFS_MODULE_CONTROL    6'h05
`define OFS_COUNTER_STATUS    6'h06

// Field positions
`define PRESCALE_MSB          2
`define PRESCALE_LSB          0
`define COMPARE_MSB           15
`define COMPARE_LSB           3
`define CHOP_ON_BIT           15
`define CHOP_DIV_MSB          9
`define CHOP_DIV_LSB          3
`define MODULE_ON_BIT         0

// Reset values
`define PRESCALE_RESET        3'h0
`define PERIOD_RESET          16'hffff
`define COMPARE_RESET         13'h0000
`define CHOP_DIV_RESET        7'h00

// Prescale codes and terminal counts
`define DIV1                  3'h0
`define DIV2                  3'h1
`define DIV4                  3'h2
`define DIV8                  3'h3
`define DIV16                 3'h4
`define DIV32                 3'h5
`define DIV64                 3'h6
`define DIV_RESERVED          3'h7
`define LIM1                  6'h00
`define LIM2                  6'h01
`define LIM4                  6'h03
`define LIM8                  6'h07
`define LIM16                 6'h0f
`define LIM32                 6'h1f
`define LIM64                 6'h3f

// Chop half period is eight prescaled counts per divider step
`define CHOP_HALF_LOW         3'h7

`endif

/* logic/pwm_clock_prescaler.v */
/*
 * Input clock prescaler: one tick per 1, 2, 4 ... 64 input clocks.
 * Assumes the select is stable while run_i is high.
 */
`timescale 1ns/1ps
`include "pwm_stb_defines.vh"

module pwm_clock_prescaler (
    input  wire       clk_i,
    input  wire       reset_n_i,
    input  wire       ce_i,
    input  wire       run_i,
    input  wire [2:0] select_i,
    output reg        tick_o
);

    reg  [5:0] count;
    reg  [5:0] limit;
    reg        active;

    // Terminal count for each code; reserved code yields no ticks
    always @*
    begin
        active = 1'b1;
        case (select_i)
            `DIV1:   limit = `LIM1;
            `DIV2:   limit = `LIM2;
            `DIV4:   limit = `LIM4;
            `DIV8:   limit = `LIM8;
            `DIV16:  limit = `LIM16;
            `DIV32:  limit = `LIM32;
            `DIV64:  limit = `LIM64;
            default:
            begin
                limit  = `LIM1;
                active = 1'b0;
            end
        endcase
    end

    // Divider counter, held clear while stopped
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count  <= 6'h00;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!run_i || !active)
            begin
                count  <= 6'h00;
                tick_o <= 1'b0;
            end
            else if (count >= limit)  // >= recovers from a late select change
            begin
                count  <= 6'h00;
                tick_o <= 1'b1;
            end
            else
            begin
                count  <= count + 6'h01;
                tick_o <= 1'b0;
            end
        end
    end

endmodule // pwm_clock_prescaler

/* logic/pwm_chop_generator.v */
/*
 * Chop clock generator: square wave of 16*(divider+1) prescaled ticks.
 * Assumes tick_i comes from the primary prescaler.
 */
`timescale 1ns/1ps
`include "pwm_stb_defines.vh"

module pwm_chop_generator (
    input  wire       clk_i,
    input  wire       reset_n_i,
    input  wire       ce_i,
    input  wire       enable_i,
    input  wire       tick_i,
    input  wire [6:0] divider_i,
    output reg        chop_o
);

    reg  [9:0] count;
    wire [9:0] half_limit;

    // Half period minus one is 8*(divider+1)-1
    assign half_limit = {divider_i, `CHOP_HALF_LOW};

    // Toggle on each half period; low and cleared while disabled
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count  <= 10'h000;
            chop_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!enable_i)
            begin
                count  <= 10'h000;
                chop_o <= 1'b0;
            end
            else if (tick_i)
            begin
                if (count >= half_limit)
                begin
                    count  <= 10'h000;
                    chop_o <= ~chop_o;
                end
                else
                begin
                    count <= count + 10'h001;
                end
            end
        end
    end

endmodule // pwm_chop_generator

/* logic/pwm_secondary_timebase_chop.v */
/*
 * Secondary master time base and chop clock generator with a classic
 * Wishbone register slave. Assumes clk_i is the PWM input clock and
 * that software obeys the period and prescale programming limits.
 */
`timescale 1ns/1ps
`include "pwm_stb_defines.vh"

module pwm_secondary_timebase_chop (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        ce_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg  [15:0] secondary_master_counter_o,
    output reg         special_event_o,
    output reg         period_wrap_o,
    output wire        chop_clock_o
);

    // Software visible state
    reg  [2:0]  sec_prescale_select;
    reg  [15:0] secondary_period_value;
    reg  [12:0] secondary_event_compare_value;
    reg         chop_generator_on;
    reg  [6:0]  chop_divider_value;
    reg  [2:0]  clock_prescale_select;
    reg         pwm_module_on;

    // Bus decode
    wire        bus_request;
    wire        bus_write;
    wire [5:0]  word_index;
    reg  [31:0] read_value;
    reg  [15:0] current_value;
    wire [15:0] merged_value;

    // Time base
    wire        sec_tick;
    wire        pri_tick;
    reg  [15:0] next_count;
    wire [15:0] compare_count;

    // Byte lane merge for the 16-bit registers
    function [15:0] merge_lanes;
        input [15:0] old_value;
        input [15:0] new_value;
        input [1:0]  lanes;
        begin
            merge_lanes[7:0]  = lanes[0] ? new_value[7:0]  : old_value[7:0];
            merge_lanes[15:8] = lanes[1] ? new_value[15:8] : old_value[15:8];
        end
    endfunction

    // One access per strobe; ack drops the cycle after it is given
    assign bus_request = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write   = bus_request && wb_we_i;
    assign word_index  = wb_adr_i[7:2];

    // Current register image, unused bits zero
    always @*
    begin
        current_value = 16'h0000;
        case (word_index)
            `OFS_SEC_PRESCALE:
                current_value[`PRESCALE_MSB:`PRESCALE_LSB] = sec_prescale_select;
            `OFS_SEC_PERIOD:
                current_value = secondary_period_value;
            `OFS_SEC_COMPARE:
                current_value[`COMPARE_MSB:`COMPARE_LSB] =
                    secondary_event_compare_value;
            `OFS_CHOP_CONTROL:
            begin
                current_value[`CHOP_ON_BIT] = chop_generator_on;
                current_value[`CHOP_DIV_MSB:`CHOP_DIV_LSB] = chop_divider_value;
            end
            `OFS_PRI_PRESCALE:
                current_value[`PRESCALE_MSB:`PRESCALE_LSB] = clock_prescale_select;
            `OFS_MODULE_CONTROL:
                current_value[`MODULE_ON_BIT] = pwm_module_on;
            `OFS_COUNTER_STATUS:
                current_value = secondary_master_counter_o;
            default:
                current_value = 16'h0000;  // Unmapped reads zero
        endcase
    end

    // Upper half of the bus word always reads zero
    always @*
    begin
        read_value = {16'h0000, current_value};
    end

    assign merged_value = merge_lanes(current_value, wb_dat_i[15:0], wb_sel_i[1:0]);

    // Wishbone answer, one cycle after the strobe
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= bus_request;
            if (bus_request && !wb_we_i)
                wb_dat_o <= read_value;
            else
                wb_dat_o <= 32'h00000000;
        end
    end

    // Register writes; unimplemented bits are simply not stored
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sec_prescale_select           <= `PRESCALE_RESET;
            secondary_period_value        <= `PERIOD_RESET;
            secondary_event_compare_value <= `COMPARE_RESET;
            chop_generator_on             <= 1'b0;
            chop_divider_value            <= `CHOP_DIV_RESET;
            clock_prescale_select         <= `PRESCALE_RESET;
            pwm_module_on                 <= 1'b0;
        end
        else if (ce_i && bus_write)
        begin
            case (word_index)
                `OFS_SEC_PRESCALE:
                    sec_prescale_select <=
                        merged_value[`PRESCALE_MSB:`PRESCALE_LSB];
                `OFS_SEC_PERIOD:
                    secondary_period_value <= merged_value;
                `OFS_SEC_COMPARE:
                    secondary_event_compare_value <=
                        merged_value[`COMPARE_MSB:`COMPARE_LSB];
                `OFS_CHOP_CONTROL:
                begin
                    chop_generator_on  <= merged_value[`CHOP_ON_BIT];
                    chop_divider_value <=
                        merged_value[`CHOP_DIV_MSB:`CHOP_DIV_LSB];
                end
                `OFS_PRI_PRESCALE:
                    clock_prescale_select <=
                        merged_value[`PRESCALE_MSB:`PRESCALE_LSB];
                `OFS_MODULE_CONTROL:
                    pwm_module_on <= merged_value[`MODULE_ON_BIT];
                default:
                    pwm_module_on <= pwm_module_on;  // Status and unmapped ignore writes
            endcase
        end
    end

    // Secondary prescaler drives the secondary counter only
    pwm_clock_prescaler u_sec_prescaler (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .run_i     (pwm_module_on),
        .select_i  (sec_prescale_select),
        .tick_o    (sec_tick)
    );

    // Primary prescaler free of the module switch, so chop runs alone
    pwm_clock_prescaler u_pri_prescaler (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .run_i     (chop_generator_on),
        .select_i  (clock_prescale_select),
        .tick_o    (pri_tick)
    );

    pwm_chop_generator u_chop (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .enable_i  (chop_generator_on),
        .tick_i    (pri_tick),
        .divider_i (chop_divider_value),
        .chop_o    (chop_clock_o)
    );

    // Compare counts in steps of eight
    assign compare_count = {secondary_event_compare_value, 3'h0};

    // Next count; >= guards against a period lowered below the count
    always @*
    begin
        if (secondary_master_counter_o >= secondary_period_value)
            next_count = 16'h0000;
        else
            next_count = secondary_master_counter_o + 16'h0001;
    end

    // Secondary master counter with match and wrap pulses
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            secondary_master_counter_o <= 16'h0000;
            special_event_o            <= 1'b0;
            period_wrap_o              <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!pwm_module_on)
            begin
                secondary_master_counter_o <= 16'h0000;
                special_event_o            <= 1'b0;
                period_wrap_o              <= 1'b0;
            end
            else if (sec_tick)
            begin
                secondary_master_counter_o <= next_count;
                special_event_o            <= (next_count == compare_count);
                period_wrap_o              <= (next_count == 16'h0000);
            end
            else
            begin
                special_event_o <= 1'b0;
                period_wrap_o   <= 1'b0;
            end
        end
    end

endmodule // pwm_secondary_timebase_chop

/* verification/stb_monitor.sv */
/* Port assertions for the secondary time base and chop block.
   Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ps

module stb_monitor (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [15:0] secondary_master_counter_o,
    input wire logic        special_event_o,
    input wire logic        period_wrap_o,
    input wire logic        chop_clock_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Bus answers once, one cycle after the request
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_answer_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    read_idle_zero_a: assert property (wb_dat_o[31:16] == 16'h0 && (wb_ack_o || wb_dat_o == 32'h0))
        else $error("read data outside answer");
    // Time base relations
    event_aligned_a: assert property (special_event_o |-> secondary_master_counter_o[2:0] == 3'h0)
        else $error("event off the eight-count grid");
    event_pulse_a: assert property (special_event_o |=> !special_event_o)
        else $error("event longer than one cycle");
    wrap_zero_a: assert property (period_wrap_o |-> secondary_master_counter_o == 16'h0
        && $past(secondary_master_counter_o) != 16'h0) else $error("wrap without return to zero");
    count_step_a: assert property ($changed(secondary_master_counter_o)
        && secondary_master_counter_o != 16'h0
        |-> secondary_master_counter_o == $past(secondary_master_counter_o) + 16'h1)
        else $error("counter skipped a value");
    // Low half period is never shorter than eight input clocks
    chop_low_min_a: assert property ($fell(chop_clock_o) |-> (!chop_clock_o)[*8])
        else $error("chop low phase too short");

    cover property (special_event_o);
    cover property (period_wrap_o);
    cover property ($rose(chop_clock_o));
    cover property (wb_ack_o && !wb_we_i);
endmodule // stb_monitor

bind pwm_secondary_timebase_chop stb_monitor i_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .secondary_master_counter_o(secondary_master_counter_o),
    .special_event_o(special_event_o), .period_wrap_o(period_wrap_o),
    .chop_clock_o(chop_clock_o));

/* verification/tb.sv */
/* Self-checking bench for the secondary time base and chop block.
   Drives the Wishbone slave and times the counter and chop outputs. */
`timescale 1ns/1ps

module tb;
    logic        clk_i, reset_n_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, special_event_o, period_wrap_o, chop_clock_o;
    logic [15:0] secondary_master_counter_o, rd, p, c, w;
    integer      seed = 38, num_errors = 0, check_count = 0, cycles = 0, n, ev, i;
    logic [7:0]  ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
    logic [15:0] msk [4] = '{16'h0007, 16'hffff, 16'hfff8, 16'h83f8};
    logic [15:0] rst [4] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000};

    pwm_secondary_timebase_chop i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .secondary_master_counter_o(secondary_master_counter_o),
        .special_event_o(special_event_o), .period_wrap_o(period_wrap_o),
        .chop_clock_o(chop_clock_o));

    // Expected cycle counts
    function integer wrap_len(input integer pp, input integer code);
        return (pp + 1) << code;
    endfunction
    function integer chop_len(input integer d, input integer code);
        return (16 * (d + 1)) << code;
    endfunction

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask

    // One classic cycle; read data lands in rd
    task wb(input logic [7:0] a, input logic we, input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Cycles between two rising edges of wrap pulse or chop clock
    task measure(input logic which);
        logic   prev, cur;
        integer k;
        prev = 1'b1;
        k = 0;
        n = 0;
        ev = 0;
        while (k < 2)
        begin
            @(posedge clk_i);
            cur = which ? chop_clock_o : period_wrap_o;
            if (k == 1)
                n++;
            if (!which && k == 1 && special_event_o === 1'b1)
            begin
                ev++;
                chk("count at event", c << 3, secondary_master_counter_o);
            end
            if (cur === 1'b1 && prev === 1'b0)
                k++;
            prev = cur;
        end
    endtask

    task end_sim;
        $display("checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard, sized well above the longest expected run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            end_sim;
        end
    end

    initial
    begin
        reset_n_i <= 1'b0;
        ce_i <= 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        wb_adr_i <= 8'h00;
        wb_sel_i <= 4'h3;
        wb_dat_i <= 32'h0;
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            wb(ofs[i], 1'b0, 16'h0);
            chk("reset value", rst[i], rd);
        end
        wb(8'h1c, 1'b1, 16'hffff);
        wb(8'h1c, 1'b0, 16'h0);
        chk("unmapped read", 32'h0, rd);
        // Random data through the field masks
        for (i = 0; i < 16; i++)
        begin
            w = $random(seed);
            wb(ofs[i % 4], 1'b1, w);
            wb(ofs[i % 4], 1'b0, 16'h0);
            chk("read back", w & msk[i % 4], rd);
        end
        // Byte lane zero alone merges into the old upper byte
        wb(8'h04, 1'b1, 16'hffff);
        wb_sel_i <= 4'h1;
        wb(8'h04, 1'b1, 16'h1234);
        wb_sel_i <= 4'h3;
        wb(8'h04, 1'b0, 16'h0);
        chk("lane merge", 32'hff34, rd);
        // Wrap length and one event per period for each prescale code DIV1 to DIV64
        wb(8'h0c, 1'b1, 16'h0);
        for (i = 0; i < 7; i++)
        begin
            p = 16'h28 + ($random(seed) & 16'h1f);
            c = ($random(seed) & 16'h1fff) % ((p >> 3) + 1);
            if (i == 0)
                {p, c} = {16'h10, 16'h0};
            wb(8'h14, 1'b1, 16'h0);
            wb(8'h00, 1'b1, i[15:0]);
            wb(8'h04, 1'b1, p);
            wb(8'h08, 1'b1, c << 3);
            wb(8'h14, 1'b1, 16'h1);
            measure(1'b0);
            chk("wrap period", wrap_len(p, i), n);
            chk("events per period", 32'h1, ev);
        end
        // Clock enable low freezes a running counter
        wb(8'h14, 1'b1, 16'h0);
        wb(8'h00, 1'b1, 16'h0);
        wb(8'h14, 1'b1, 16'h1);
        repeat (5) @(posedge clk_i);
        ce_i <= 1'b0;
        @(posedge clk_i);
        w = secondary_master_counter_o;
        repeat (20) @(posedge clk_i);
        chk("frozen count", w, secondary_master_counter_o);
        ce_i <= 1'b1;
        // Reserved code gives no ticks
        wb(8'h14, 1'b1, 16'h0);
        wb(8'h00, 1'b1, 16'h7);
        wb(8'h14, 1'b1, 16'h1);
        repeat (100) @(posedge clk_i);
        chk("reserved code count", 32'h0, secondary_master_counter_o);
        // Chop timing with a slow secondary prescale set
        wb(8'h14, 1'b1, 16'h0);
        wb(8'h00, 1'b1, 16'h6);
        for (i = 0; i < 5; i++)
        begin
            w = (i == 0) ? 16'h0 : (i == 4) ? 16'h7f : ($random(seed) & 16'hf);
            p = (i == 4) ? 16'h0 : i % 3;
            wb(8'h0c, 1'b1, 16'h0);
            wb(8'h10, 1'b1, p);
            wb(8'h0c, 1'b1, 16'h8000 | (w << 3));
            measure(1'b1);
            chk("chop period", chop_len(w, p), n);
        end
        wb(8'h0c, 1'b1, 16'h0);
        repeat (3) @(posedge clk_i);
        chk("chop stopped", 32'h0, chop_clock_o);
        end_sim;
    end
endmodule // tb
